//--- logic/jtap_pkg.sv
// jtap_pkg: constants, states and carriers of the boundary-scan test access port
// assumes: imported by jtap_sync and jtap_top; no timing constants needed here
package jtap_pkg;

  // instruction register
  localparam int unsigned JTAP_IR_W        = 3;
  localparam logic [2:0]  JTAP_IR_EXTEST   = 3'h0;  // drive pins from update stage
  localparam logic [2:0]  JTAP_IR_SAMPLE   = 3'h1;  // capture pins, no disturbance
  localparam logic [2:0]  JTAP_IR_HIGHZ    = 3'h2;  // output-only pins released
  localparam logic [2:0]  JTAP_IR_BYPASS   = 3'h7;  // one-bit path
  localparam logic [2:0]  JTAP_IR_CAPTURE  = 3'h1;  // fixed capture pattern, low bits 01
  localparam logic [2:0]  JTAP_IR_RESET    = JTAP_IR_BYPASS;

  // boundary register defaults
  localparam int unsigned JTAP_BSR_LEN     = 8;
  localparam logic        JTAP_BYP_CAPTURE = 1'b0;  // bypass cell captures zero

  // synchroniser depth for pad inputs
  localparam int unsigned JTAP_SYNC_STAGES = 2;

  // pad idle levels, also the synchroniser reset levels, so no false edge follows reset
  localparam logic        JTAP_TCK_IDLE    = 1'b1;  // tester parks tck high
  localparam logic        JTAP_TMS_IDLE    = 1'b1;  // pulled up outside
  localparam logic        JTAP_TDI_IDLE    = 1'b0;  // level is irrelevant outside shift

  // tap controller states, binary codes
  typedef enum logic [3:0] {
    JTAP_TLR    = 4'h0,
    JTAP_RTI    = 4'h1,
    JTAP_SEL_DR = 4'h2,
    JTAP_CAP_DR = 4'h3,
    JTAP_SH_DR  = 4'h4,
    JTAP_EX1_DR = 4'h5,
    JTAP_PA_DR  = 4'h6,
    JTAP_EX2_DR = 4'h7,
    JTAP_UPD_DR = 4'h8,
    JTAP_SEL_IR = 4'h9,
    JTAP_CAP_IR = 4'ha,
    JTAP_SH_IR  = 4'hb,
    JTAP_EX1_IR = 4'hc,
    JTAP_PA_IR  = 4'hd,
    JTAP_EX2_IR = 4'he,
    JTAP_UPD_IR = 4'hf
  } jtap_state_t;

  // the serial test pins that travel together
  typedef struct packed {
    logic tck;  // test clock
    logic tms;  // mode select
    logic tdi;  // serial data in
  } jtap_pins_t;

  localparam int unsigned JTAP_PINS_W = $bits(jtap_pins_t);

endpackage : jtap_pkg

//--- logic/jtap_sync.sv
// jtap_sync: two-flop synchroniser for a vector of pad inputs, with edge finder on bit 0
// assumes: inputs asynchronous to clk; bit 0 carries a slow clock whose edges are wanted
`timescale 1ns/10ps
`default_nettype none
module jtap_sync #(
  parameter int unsigned  W       = 1,  // vector width
  parameter logic [W-1:0] RST_VAL = '0  // level taken during reset, the pad idle level
) (
  input  wire logic         clk,     // sampling clock
  input  wire logic         resetn,  // async reset, low active
  input  wire logic [W-1:0] async_in, // pad levels
  output logic      [W-1:0] sync_out, // synchronised levels
  output logic              rise,    // bit 0 rose, one cycle
  output logic              fall     // bit 0 fell, one cycle
);
  import jtap_pkg::*;

  logic [W-1:0] meta;
  logic         last0;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

  // edge finder looks at the second stage only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last0 <= RST_VAL[0];  // matches the reset level of the second stage
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      last0 <= sync_out[0];
      rise  <= sync_out[0] & ~last0;
      fall  <= ~sync_out[0] & last0;
    end
  end

endmodule : jtap_sync
`default_nettype wire

//--- logic/jtap_top.sv
// jtap_top: boundary-scan test access port with 16-state controller
// assumes: tck/tms/tdi arrive from pads, asynchronous to mclk, tck much slower than mclk;
// sys_pin_in comes from functional pads; pin outputs go to the pad muxes
//
// Overview of operation
// - four dedicated pins: tck, tms, tdi, tdo
// - sixteen-state tap controller per standard
// - all test logic advanced by test clock
// - tms sampled on rising test clock edges
// - extest drives and captures pins for continuity
// - bypass shortens path to one cell
// - sample captures pins without disturbing operation
// - highz instruction releases output-only pins
// - static state survives stopped or slow clock
`timescale 1ns/10ps
`default_nettype none
module jtap_top #(
  parameter int unsigned BSR_LEN = jtap_pkg::JTAP_BSR_LEN  // boundary cells
) (
  input  wire logic               mclk,        // sampling clock, 200 MHz
  input  wire logic               resetn,      // async reset, low active
  input  wire logic               tck,         // test clock pad
  input  wire logic               tms,         // mode select pad, pulled up outside
  input  wire logic               tdi,         // serial data in pad
  output logic                    tdo,         // serial data out
  output logic                    tdo_oe_n,    // low while tdo is driven
  input  wire logic [BSR_LEN-1:0] sys_pin_in,  // functional pin levels
  output logic      [BSR_LEN-1:0] pin_test_val, // values to force on pins
  output logic                    pin_test_en, // pins take pin_test_val
  output logic                    out_hiz,     // release output-only drivers
  output logic                    tap_reset    // controller in test-logic-reset
);
  import jtap_pkg::*;

  jtap_pins_t   pins_raw;
  jtap_pins_t   pins;
  logic         tck_rise;
  logic         tck_fall;
  logic [BSR_LEN-1:0] pin_sync;

  jtap_state_t  state;
  jtap_state_t  next_state;
  logic [JTAP_IR_W-1:0] ir_shift;
  logic [JTAP_IR_W-1:0] ir_active;
  logic [BSR_LEN-1:0]   bsr_shift;
  logic                 byp_cell;
  logic                 sel_bsr;
  logic                 serial_out;

  assign pins_raw = '{tck: tck, tms: tms, tdi: tdi};

  // pad inputs pass two flops; they reset to the pad idle levels
  jtap_sync #(
    .W       (JTAP_PINS_W),
    .RST_VAL ({JTAP_TCK_IDLE, JTAP_TMS_IDLE, JTAP_TDI_IDLE})
  ) u_pin_sync (
    .clk      (mclk),
    .resetn   (resetn),
    .async_in ({pins_raw.tck, pins_raw.tms, pins_raw.tdi}),
    .sync_out ({pins.tck, pins.tms, pins.tdi}),
    .rise     (),
    .fall     ()
  );

  // separate finder on the clock bit, ordering puts tdi at bit 0
  // reset to the parked high level, else the first edges after reset fake a rise
  jtap_sync #(
    .W       (1),
    .RST_VAL (JTAP_TCK_IDLE)
  ) u_tck_edge (
    .clk      (mclk),
    .resetn   (resetn),
    .async_in (pins_raw.tck),
    .sync_out (),
    .rise     (tck_rise),
    .fall     (tck_fall)
  );

  // functional pins are sampled, never loaded, so operation is undisturbed
  jtap_sync #(.W(BSR_LEN)) u_sys_sync (
    .clk      (mclk),
    .resetn   (resetn),
    .async_in (sys_pin_in),
    .sync_out (pin_sync),
    .rise     (),
    .fall     ()
  );

  // next state of the controller from sampled tms
  always_comb begin
    case (state)
      JTAP_TLR:    next_state = pins.tms ? JTAP_TLR    : JTAP_RTI;
      JTAP_RTI:    next_state = pins.tms ? JTAP_SEL_DR : JTAP_RTI;
      JTAP_SEL_DR: next_state = pins.tms ? JTAP_SEL_IR : JTAP_CAP_DR;
      JTAP_CAP_DR: next_state = pins.tms ? JTAP_EX1_DR : JTAP_SH_DR;
      JTAP_SH_DR:  next_state = pins.tms ? JTAP_EX1_DR : JTAP_SH_DR;
      JTAP_EX1_DR: next_state = pins.tms ? JTAP_UPD_DR : JTAP_PA_DR;
      JTAP_PA_DR:  next_state = pins.tms ? JTAP_EX2_DR : JTAP_PA_DR;
      JTAP_EX2_DR: next_state = pins.tms ? JTAP_UPD_DR : JTAP_SH_DR;
      JTAP_UPD_DR: next_state = pins.tms ? JTAP_SEL_DR : JTAP_RTI;
      JTAP_SEL_IR: next_state = pins.tms ? JTAP_TLR    : JTAP_CAP_IR;
      JTAP_CAP_IR: next_state = pins.tms ? JTAP_EX1_IR : JTAP_SH_IR;
      JTAP_SH_IR:  next_state = pins.tms ? JTAP_EX1_IR : JTAP_SH_IR;
      JTAP_EX1_IR: next_state = pins.tms ? JTAP_UPD_IR : JTAP_PA_IR;
      JTAP_PA_IR:  next_state = pins.tms ? JTAP_EX2_IR : JTAP_PA_IR;
      JTAP_EX2_IR: next_state = pins.tms ? JTAP_UPD_IR : JTAP_SH_IR;
      JTAP_UPD_IR: next_state = pins.tms ? JTAP_SEL_DR : JTAP_RTI;
      default:     next_state = JTAP_TLR;
    endcase
  end

  // controller moves only on a rising test clock; a stopped tck holds every flop behind the synchronisers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= JTAP_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction shift path; capture loads the fixed 01 pattern
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ir_shift <= JTAP_IR_RESET;
    end else if (tck_rise) begin
      if (state == JTAP_CAP_IR) begin
        ir_shift <= JTAP_IR_CAPTURE;
      end else if (state == JTAP_SH_IR) begin
        ir_shift <= {pins.tdi, ir_shift[JTAP_IR_W-1:1]};
      end
    end
  end

  // active instruction and the pin controls it implies, applied on falling edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ir_active   <= JTAP_IR_RESET;
      pin_test_en <= 1'b0;
      out_hiz     <= 1'b0;
    end else if (tck_fall) begin
      if (state == JTAP_TLR) begin
        ir_active   <= JTAP_IR_RESET;
        pin_test_en <= 1'b0;
        out_hiz     <= 1'b0;
      end else if (state == JTAP_UPD_IR) begin
        ir_active   <= ir_shift;
        pin_test_en <= (ir_shift == JTAP_IR_EXTEST);
        out_hiz     <= (ir_shift == JTAP_IR_HIGHZ);
      end
    end
  end

  // unknown codes behave as bypass, so a bad scan cannot touch the pins
  assign sel_bsr = (ir_active == JTAP_IR_EXTEST) || (ir_active == JTAP_IR_SAMPLE);

  // boundary shift register: capture pin levels, then shift
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bsr_shift <= '0;
    end else if (tck_rise && sel_bsr) begin
      if (state == JTAP_CAP_DR) begin
        bsr_shift <= pin_sync;
      end else if (state == JTAP_SH_DR) begin
        bsr_shift <= {pins.tdi, bsr_shift[BSR_LEN-1:1]};
      end
    end
  end

  // update stage holds forced values so shifting never glitches the pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_test_val <= '0;
    end else if (tck_fall && sel_bsr && state == JTAP_UPD_DR) begin
      pin_test_val <= bsr_shift;
    end
  end

  // single bypass cell
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      byp_cell <= JTAP_BYP_CAPTURE;
    end else if (tck_rise && !sel_bsr) begin
      if (state == JTAP_CAP_DR) begin
        byp_cell <= JTAP_BYP_CAPTURE;
      end else if (state == JTAP_SH_DR) begin
        byp_cell <= pins.tdi;
      end
    end
  end

  // pick the cell that faces tdo
  always_comb begin
    if (state == JTAP_SH_IR) begin
      serial_out = ir_shift[0];
    end else if (sel_bsr) begin
      serial_out = bsr_shift[0];
    end else begin
      serial_out = byp_cell;
    end
  end

  // tdo changes up to 4 mclk after tck falls, leaving the tester the rest of the low phase as setup
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo      <= serial_out;
      tdo_oe_n <= !((state == JTAP_SH_DR) || (state == JTAP_SH_IR));
    end
  end

  // reset indication, registered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tap_reset <= 1'b1;
    end else begin
      tap_reset <= (state == JTAP_TLR);
    end
  end

endmodule : jtap_top
`default_nettype wire

//--- test/jtap_tester.sv
// jtap_tester: board tester model, one tck period of 26 mclk per bit
// assumes: mclk at 200 MHz, so tck runs at 130 ns only within frames
`timescale 1ns/10ps
`default_nettype none
module jtap_tester (
  input  wire logic mclk,  // bench clock
  input  wire logic tdo,   // device serial out
  output logic      tck,   // test clock, stands high between frames
  output logic      tms,   // mode select
  output logic      tdi    // serial data in
);
  // idle levels at time zero
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one bit: fall, present tms and tdi, read tdo late in the low phase, rise
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge mclk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (12) @(posedge mclk);
    o = tdo;
    tck <= 1'b1;
    repeat (13) @(posedge mclk);
  endtask : step
  // released: pull-up wins on tms, tdi shows a changed level, not the old one
  task automatic rest();
    @(posedge mclk);
    tms <= 1'b1;
    tdi <= ~tdi;
  endtask : rest
endmodule : jtap_tester
`default_nettype wire

//--- test/jtap_top_sva.sv
// jtap_top_sva: timing checks on the outputs of the test access port
// assumes: bound into jtap_top; tck high and low phases last well over 8 mclk
`timescale 1ns/10ps
`default_nettype none
module jtap_top_sva #(
  parameter int unsigned BSR_LEN = 8  // boundary cells
) (
  input wire logic               mclk,         // sampling clock
  input wire logic               resetn,       // async reset, low active
  input wire logic               tck,          // test clock pad
  input wire logic               tms,          // mode select pad
  input wire logic               tdi,          // serial data in
  input wire logic               tdo,          // serial data out
  input wire logic               tdo_oe_n,     // low while tdo driven
  input wire logic [BSR_LEN-1:0] sys_pin_in,   // functional pin levels
  input wire logic [BSR_LEN-1:0] pin_test_val, // forced pin values
  input wire logic               pin_test_en,  // pins forced
  input wire logic               out_hiz,      // output-only drivers released
  input wire logic               tap_reset     // controller in reset state
);
  logic [2:0] ones;  // tck rises seen in a row with tms high
  // saturating count, so a long idle in reset does not wrap
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ones <= 3'h0;
    else if ($rose(tck)) ones <= !tms ? 3'h0 : (ones == 3'h5 ? ones : ones + 3'h1);
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_stop_holds: assert property ($stable(tck) [*6] |=> $stable({tdo, tdo_oe_n, pin_test_val, pin_test_en, out_hiz, tap_reset})) else $error("output moved while tck stood still");
  a_oe_on_fall: assert property ($changed(tdo_oe_n) |-> !tck && !$past(tck) && !$past(tck, 2)) else $error("tdo enable moved outside tck low");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !tck && !$past(tck) && !$past(tck, 2)) else $error("tdo moved outside tck low");
  a_pins_on_fall: assert property (!tap_reset && ($changed(pin_test_val) || $changed(pin_test_en)) |-> !tck && !$past(tck, 2)) else $error("pin values moved outside tck low");
  a_hiz_on_fall: assert property (!tap_reset && $changed(out_hiz) |-> !tck && !$past(tck, 2)) else $error("release moved outside tck low");
  a_five_ones: assert property ($rose(tck) && tms && ones == 3'h4 |-> ##[1:8] tap_reset) else $error("five high tms did not reset");
  a_tlr_quiet: assert property ((tap_reset && !tck) [*8] |-> tdo_oe_n && !pin_test_en && !out_hiz) else $error("reset state not benign");
  a_hiz_excl: assert property (!(out_hiz && pin_test_en)) else $error("release and force together");
  c_hiz: cover property ($rose(out_hiz));
  c_force: cover property ($rose(pin_test_en));
  c_shift: cover property ($fell(tdo_oe_n));
endmodule : jtap_top_sva
bind jtap_top jtap_top_sva #(.BSR_LEN(BSR_LEN)) u_sva (.mclk(mclk), .resetn(resetn),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .sys_pin_in(sys_pin_in),
  .pin_test_val(pin_test_val), .pin_test_en(pin_test_en), .out_hiz(out_hiz),
  .tap_reset(tap_reset));
`default_nettype wire

//--- test/jtap_top_tb.sv
// jtap_top_tb: loads every instruction, scans ir and dr, checks serial and pin results
// assumes: jtap_pkg, jtap_tester and the checker compiled before this file
`timescale 1ns/10ps
`default_nettype none
module jtap_top_tb;
  import jtap_pkg::*;
  localparam int unsigned N = JTAP_BSR_LEN;
  logic         mclk, resetn, tdo, tdo_oe_n, pin_test_en, out_hiz, tap_reset, o;
  logic [N-1:0] sys_pin_in, pin_test_val, exp_pins;
  logic [2:0]   ir;
  logic [31:0]  lfsr, got, din, exp_ser;
  wire logic    tck, tms, tdi;
  int           err_count, cmp_count;
  bit           q[$];
  logic [2:0]   codes[5] = '{JTAP_IR_HIGHZ, JTAP_IR_SAMPLE, JTAP_IR_BYPASS, 3'h5, JTAP_IR_EXTEST};
  jtap_top #(.BSR_LEN(N)) dut (.mclk(mclk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .sys_pin_in(sys_pin_in), .pin_test_val(pin_test_val),
    .pin_test_en(pin_test_en), .out_hiz(out_hiz), .tap_reset(tap_reset));
  jtap_tester tst (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  // bench clock, 5 ns
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk_bits(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: value %h expected %h", $time, g, e);
    end
  endtask : chk_bits
  task automatic chk_flags(input logic [3:0] e);
    cmp_count++;
    if ({tap_reset, tdo_oe_n, out_hiz, pin_test_en} !== e) begin
      err_count++;
      $display("mismatch at %0t: flags %b expected %b", $time,
               {tap_reset, tdo_oe_n, out_hiz, pin_test_en}, e);
    end
  endtask : chk_flags
  // walk from idle through one scan; the queue model is the selected path
  task automatic scan(input logic is_ir, input int n);
    logic oe_seen;
    q.delete();
    oe_seen = 1'b0;
    got = '0;
    exp_ser = '0;
    if (is_ir) for (int k = 0; k < JTAP_IR_W; k++) q.push_back(JTAP_IR_CAPTURE[k]);
    else if (ir == JTAP_IR_EXTEST || ir == JTAP_IR_SAMPLE) for (int k = 0; k < N; k++) q.push_back(sys_pin_in[k]);
    else q.push_back(JTAP_BYP_CAPTURE);
    tst.step(1'b1, 1'b0, o);
    if (is_ir) tst.step(1'b1, 1'b0, o);
    tst.step(1'b0, 1'b0, o);
    tst.step(1'b0, 1'b0, o);
    for (int k = 0; k < n; k++) begin
      tst.step(k == n - 1, din[k], o);
      got[k] = o;
      exp_ser[k] = q.pop_front();
      q.push_back(din[k]);
      oe_seen |= tdo_oe_n;
    end
    tst.step(1'b1, 1'b0, o);
    tst.step(1'b0, 1'b0, o);
    tst.rest();
    chk_bits({31'h0, oe_seen}, 32'h0);
    if (is_ir) ir = {q[2], q[1], q[0]};
    else if (ir == JTAP_IR_EXTEST || ir == JTAP_IR_SAMPLE) for (int k = 0; k < N; k++) exp_pins[k] = q[k];
  endtask : scan
  task automatic end_sim();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // main sequence: reset, every instruction, then return to reset by tms
  initial begin
    resetn = 1'b0;
    sys_pin_in = '0;
    lfsr = 32'h29e7;
    ir = JTAP_IR_RESET;
    exp_pins = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_flags(4'b1100);
    $display("test reset levels done");
    tst.step(1'b0, 1'b0, o);
    foreach (codes[i]) begin
      lfsr = nxt(lfsr);
      sys_pin_in <= lfsr[N-1:0];
      din = 32'(codes[i]);
      scan(1'b1, JTAP_IR_W);
      chk_bits(got, exp_ser);
      chk_flags({2'b01, ir == JTAP_IR_HIGHZ, ir == JTAP_IR_EXTEST});
      lfsr = nxt(lfsr);
      din = lfsr;
      scan(1'b0, N + 2);
      chk_bits(got, exp_ser);
      chk_bits(32'(pin_test_val), 32'(exp_pins));
      $display("test instruction %h done", codes[i]);
    end
    repeat (6) tst.step(1'b1, 1'b0, o);
    repeat (2) @(posedge mclk);
    ir = JTAP_IR_RESET;
    chk_flags(4'b1100);
    $display("test return to reset done");
    end_sim();
  end
  // watchdog: about nine times the expected run
  initial begin
    repeat (30000) @(posedge mclk);
    err_count++;
    end_sim();
  end
endmodule : jtap_top_tb
`default_nettype wire
